// ### logic/vhio_decode.sv
// Host I/O register decode and general control registers of the video controller
//
// Contract
// - Host moves one byte per addressed read/write.
// - Trapped legacy port access pulls NMI low.
// - Direction output follows read versus write.
// - Undocumented ports have no register effect.
// - Display data latches are readable by host.
// - Palette index read/write at separate ports.
// - Output control written one port, read another.
// - Bit 0 relocates timing ports, 3Bx/3Dx.
// - Bits 7:6 encode vertical size.
// - Bit 5 picks odd/even memory page.
// - Bits 3:2 plus extended bit pick clock.
// - Bit 1 gates host display memory decode.
// - Status bit 7 shows pending retrace interrupt.
// - Retrace interrupt is active-low open collector.
// - NMI output active low open collector.
// - Monitor detect shown in status bit 4.
// - Subsystem enable bit 0 gates all decode except its own port.
`timescale 1ns/1ps
module vhio_decode (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire vhio_pkg::vhio_req_s host_req,
  input  wire logic               vretrace,
  input  wire logic               hretrace,
  input  wire logic               retrace_clear,
  input  wire logic               monitor_switch,
  input  wire logic [7:0]         data_latch,
  input  wire logic [7:0]         attr_rd_data,
  input  wire logic [7:0]         unit_rd_data,
  input  wire logic [7:0]         palette_rd_data,
  input  wire logic [1:0]         diag_color,
  input  wire logic               nmi_ack,
  output logic [7:0]              host_rdata,
  output logic                    host_rvalid,
  output vhio_pkg::vhio_ctl_s     ctl,
  output logic                    retrace_irq_n,
  output logic                    retrace_irq_oe_n,
  output logic                    nmi_n,
  output logic                    nmi_oe_n,
  output logic                    xcvr_dir,
  output logic                    data_buffer_en_n,
  output logic                    palette_write_n,
  output logic                    palette_read_n,
  output logic [7:0]              palette_index_out,
  output logic                    unit_wr,
  output logic [15:0]             unit_addr,
  output logic [7:0]              unit_wdata,
  output logic                    vsync_or_display
);
  // Pin synchronisers
  logic [1:0] vr_sync_ff;
  logic [1:0] hr_sync_ff;
  logic [1:0] sw_sync_ff;
  logic       vr_last_ff;
  logic [7:0] outctl_ff;
  logic [7:0] subsys_ff;
  logic [7:0] feature_ff;
  logic [7:0] ext_idx_ff;
  logic       clk_sel2_ff;
  logic [7:0] pal_rd_idx_ff;
  logic [7:0] pal_wr_idx_ff;
  logic       irq_pend_ff;
  logic       nmi_ff;
  logic [7:0] nxt_rdata;
  logic       hit;
  logic       mono_hit;
  logic       color_hit;
  logic       trap_hit;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [15:0] a;

  assign a   = host_req.addr;
  assign acc = host_req.rd | host_req.wr;
  assign wr  = host_req.wr & subsys_ff[vhio_pkg::SE_EN_BIT] | host_req.wr &
               (a == vhio_pkg::PORT_SUBSYS_EN);
  assign rd  = host_req.rd & (subsys_ff[vhio_pkg::SE_EN_BIT] |
               (a == vhio_pkg::PORT_SUBSYS_EN));
  assign mono_hit  = ~outctl_ff[vhio_pkg::OC_COLOR_BIT];
  assign color_hit = outctl_ff[vhio_pkg::OC_COLOR_BIT];
  assign trap_hit  = subsys_ff[vhio_pkg::SE_EN_BIT] &
                     (a == vhio_pkg::TRAP_PORT_A | a == vhio_pkg::TRAP_PORT_B |
                      a == vhio_pkg::TRAP_PORT_C);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vr_sync_ff <= 2'h0;
      hr_sync_ff <= 2'h0;
      sw_sync_ff <= 2'h0;
    end else begin
      vr_sync_ff <= {vr_sync_ff[0], vretrace};
      hr_sync_ff <= {hr_sync_ff[0], hretrace};
      sw_sync_ff <= {sw_sync_ff[0], monitor_switch};
    end
  end

  // Control registers written by the host
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      outctl_ff     <= vhio_pkg::OUTCTL_RST;
      subsys_ff     <= vhio_pkg::SUBSYS_RST;
      feature_ff    <= vhio_pkg::BYTE_ZERO;
      ext_idx_ff    <= vhio_pkg::BYTE_ZERO;
      clk_sel2_ff   <= 1'b0;
      pal_rd_idx_ff <= vhio_pkg::BYTE_ZERO;
      pal_wr_idx_ff <= vhio_pkg::BYTE_ZERO;
    end else if (wr) begin
      unique case (a)
        vhio_pkg::PORT_OUTCTL_WR: outctl_ff <= host_req.wdata;
        vhio_pkg::PORT_SUBSYS_EN: subsys_ff <= {7'h00, host_req.wdata[vhio_pkg::SE_EN_BIT]};
        vhio_pkg::PORT_STATUS1_MONO:
          if (mono_hit) feature_ff <= {4'h0, host_req.wdata[3:0]};
        vhio_pkg::PORT_STATUS1_COLOR:
          if (color_hit) feature_ff <= {4'h0, host_req.wdata[3:0]};
        vhio_pkg::PORT_EXT_IDX: ext_idx_ff <= host_req.wdata;
        vhio_pkg::PORT_EXT_DAT:
          if (ext_idx_ff == vhio_pkg::EXT_CLK_IDX) begin
            clk_sel2_ff <= host_req.wdata[vhio_pkg::EXT_CLK_BIT];
          end
        vhio_pkg::PORT_PAL_RD_IDX: pal_rd_idx_ff <= host_req.wdata;
        vhio_pkg::PORT_PAL_WR_IDX: pal_wr_idx_ff <= host_req.wdata;
        default: ;
      endcase
    end
  end

  // Decoded control outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl <= '0;
      vsync_or_display <= 1'b0;
    end else begin
      ctl.color_map     <= outctl_ff[vhio_pkg::OC_COLOR_BIT];
      ctl.mem_decode_en <= outctl_ff[vhio_pkg::OC_MEMEN_BIT] &
                           subsys_ff[vhio_pkg::SE_EN_BIT];
      ctl.clk_sel       <= vhio_pkg::vhio_clk_e'({clk_sel2_ff,
                           outctl_ff[vhio_pkg::OC_CLK_LO +: 2]});
      ctl.high_page     <= outctl_ff[vhio_pkg::OC_PAGE_BIT];
      ctl.vsize         <= vhio_pkg::vhio_vsize_e'(outctl_ff[vhio_pkg::OC_VSIZE_LO +: 2]);
      vsync_or_display  <= feature_ff[vhio_pkg::FC_VSOR_BIT];
    end
  end

  // Pending retrace flag; a new retrace edge wins over a clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vr_last_ff  <= 1'b0;
      irq_pend_ff <= 1'b0;
    end else begin
      vr_last_ff <= vr_sync_ff[1];
      if (vr_sync_ff[1] & ~vr_last_ff) irq_pend_ff <= 1'b1;
      else if (retrace_clear) irq_pend_ff <= 1'b0;
    end
  end

  // Open-collector interrupt pins: output held low, enable low when pulling
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      retrace_irq_n    <= 1'b1;
      retrace_irq_oe_n <= 1'b1;
      nmi_ff           <= 1'b0;
      nmi_n            <= 1'b1;
      nmi_oe_n         <= 1'b1;
    end else begin
      retrace_irq_n    <= 1'b0;
      retrace_irq_oe_n <= ~irq_pend_ff;
      if (acc & trap_hit) nmi_ff <= 1'b1;
      else if (nmi_ack) nmi_ff <= 1'b0;
      nmi_n    <= 1'b0;
      nmi_oe_n <= ~nmi_ff;
    end
  end

  // Read data mux
  always_comb begin
    nxt_rdata = vhio_pkg::BYTE_ZERO;
    hit       = 1'b1;
    unique case (a)
      vhio_pkg::PORT_STATUS0_RD: begin
        nxt_rdata[vhio_pkg::ST0_IRQ_BIT]    = irq_pend_ff;
        nxt_rdata[vhio_pkg::ST0_SWITCH_BIT] = sw_sync_ff[1];
      end
      vhio_pkg::PORT_OUTCTL_RD: nxt_rdata = outctl_ff;
      vhio_pkg::PORT_SUBSYS_EN: nxt_rdata = subsys_ff;
      vhio_pkg::PORT_FEATURE_RD: nxt_rdata = feature_ff;
      vhio_pkg::PORT_STATUS1_MONO, vhio_pkg::PORT_STATUS1_COLOR: begin
        hit = (a == vhio_pkg::PORT_STATUS1_COLOR) ? color_hit : mono_hit;
        nxt_rdata[5:4] = diag_color;
        nxt_rdata[vhio_pkg::ST1_VRT_BIT]  = vr_sync_ff[1];
        nxt_rdata[vhio_pkg::ST1_RETR_BIT] = vr_sync_ff[1] | hr_sync_ff[1];
      end
      vhio_pkg::PORT_PAL_WR_IDX: nxt_rdata = pal_wr_idx_ff;
      vhio_pkg::PORT_PAL_RD_IDX, vhio_pkg::PORT_PAL_DATA, vhio_pkg::PORT_PIXEL_MASK:
        nxt_rdata = palette_rd_data;
      vhio_pkg::PORT_EXT_IDX: nxt_rdata = ext_idx_ff;
      vhio_pkg::PORT_EXT_DAT:
        nxt_rdata = (ext_idx_ff == vhio_pkg::EXT_CLK_IDX) ? {7'h00, clk_sel2_ff} :
                    data_latch;
      vhio_pkg::PORT_ATTR_IDX_WR, vhio_pkg::PORT_ATTR_RD: nxt_rdata = attr_rd_data;
      vhio_pkg::PORT_MEMT_IDX, vhio_pkg::PORT_MEMT_DAT, vhio_pkg::PORT_PIX_IDX,
      vhio_pkg::PORT_PIX_DAT:
        nxt_rdata = unit_rd_data;
      vhio_pkg::PORT_TIMING_IDX_MONO, vhio_pkg::PORT_TIMING_DAT_MONO: begin
        hit = mono_hit;
        nxt_rdata = unit_rd_data;
      end
      vhio_pkg::PORT_TIMING_IDX_COLOR, vhio_pkg::PORT_TIMING_DAT_COLOR: begin
        hit = color_hit;
        nxt_rdata = unit_rd_data;
      end
      default: hit = 1'b0;
    endcase
  end

  // Host answer, transceiver steering and palette strobes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      host_rdata        <= vhio_pkg::BYTE_ZERO;
      host_rvalid       <= 1'b0;
      xcvr_dir          <= 1'b0;
      data_buffer_en_n  <= 1'b1;
      palette_write_n   <= 1'b1;
      palette_read_n    <= 1'b1;
      palette_index_out <= vhio_pkg::BYTE_ZERO;
    end else begin
      host_rvalid       <= rd;
      host_rdata        <= (rd & hit) ? nxt_rdata : vhio_pkg::BYTE_ZERO;
      xcvr_dir          <= host_req.rd;
      data_buffer_en_n  <= ~((rd & hit) | wr);
      palette_write_n   <= ~(wr & (a == vhio_pkg::PORT_PAL_DATA | a ==
                           vhio_pkg::PORT_PIXEL_MASK | a == vhio_pkg::PORT_PAL_WR_IDX |
                           a == vhio_pkg::PORT_PAL_RD_IDX));
      palette_read_n    <= ~(rd & (a == vhio_pkg::PORT_PAL_DATA | a ==
                           vhio_pkg::PORT_PIXEL_MASK | a == vhio_pkg::PORT_PAL_RD_IDX));
      palette_index_out <= pal_wr_idx_ff;
    end
  end

  // Forward writes for the sub-units whose index/data pairs live elsewhere
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      unit_wr    <= 1'b0;
      unit_addr  <= 16'h0000;
      unit_wdata <= vhio_pkg::BYTE_ZERO;
    end else begin
      unit_wr    <= wr & ((a == vhio_pkg::PORT_TIMING_IDX_MONO |
                    a == vhio_pkg::PORT_TIMING_DAT_MONO) & mono_hit |
                    (a == vhio_pkg::PORT_TIMING_IDX_COLOR |
                    a == vhio_pkg::PORT_TIMING_DAT_COLOR) & color_hit |
                    a == vhio_pkg::PORT_MEMT_IDX | a == vhio_pkg::PORT_MEMT_DAT |
                    a == vhio_pkg::PORT_PIX_IDX | a == vhio_pkg::PORT_PIX_DAT |
                    a == vhio_pkg::PORT_ATTR_IDX_WR);
      unit_addr  <= a;
      unit_wdata <= host_req.wdata;
    end
  end
endmodule

// ### logic/vhio_pkg.sv
// Package of port addresses, field positions and carriers for the host I/O decode
package vhio_pkg;
  localparam logic [15:0] PORT_TIMING_IDX_MONO   = 16'h03b4;
  localparam logic [15:0] PORT_TIMING_DAT_MONO   = 16'h03b5;
  localparam logic [15:0] PORT_STATUS1_MONO      = 16'h03ba;
  localparam logic [15:0] PORT_ATTR_IDX_WR       = 16'h03c0;
  localparam logic [15:0] PORT_ATTR_RD           = 16'h03c1;
  localparam logic [15:0] PORT_OUTCTL_WR         = 16'h03c2;
  localparam logic [15:0] PORT_STATUS0_RD        = 16'h03c2;
  localparam logic [15:0] PORT_SUBSYS_EN         = 16'h03c3;
  localparam logic [15:0] PORT_MEMT_IDX          = 16'h03c4;
  localparam logic [15:0] PORT_MEMT_DAT          = 16'h03c5;
  localparam logic [15:0] PORT_PIXEL_MASK        = 16'h03c6;
  localparam logic [15:0] PORT_PAL_RD_IDX        = 16'h03c7;
  localparam logic [15:0] PORT_PAL_WR_IDX        = 16'h03c8;
  localparam logic [15:0] PORT_PAL_DATA          = 16'h03c9;
  localparam logic [15:0] PORT_FEATURE_RD        = 16'h03ca;
  localparam logic [15:0] PORT_OUTCTL_RD         = 16'h03cc;
  localparam logic [15:0] PORT_PIX_IDX           = 16'h03ce;
  localparam logic [15:0] PORT_PIX_DAT           = 16'h03cf;
  localparam logic [15:0] PORT_TIMING_IDX_COLOR  = 16'h03d4;
  localparam logic [15:0] PORT_TIMING_DAT_COLOR  = 16'h03d5;
  localparam logic [15:0] PORT_STATUS1_COLOR     = 16'h03da;
  localparam logic [15:0] PORT_EXT_IDX           = 16'h03de;
  localparam logic [15:0] PORT_EXT_DAT           = 16'h03df;
  // Field positions in output_control
  localparam int OC_COLOR_BIT   = 0;
  localparam int OC_MEMEN_BIT   = 1;
  localparam int OC_CLK_LO      = 2;
  localparam int OC_PAGE_BIT    = 5;
  localparam int OC_VSIZE_LO    = 6;
  // Field positions in status ports, subsystem enable and feature control
  localparam int ST0_IRQ_BIT    = 7;
  localparam int ST0_SWITCH_BIT = 4;
  localparam int ST1_VRT_BIT    = 3;
  localparam int ST1_RETR_BIT   = 0;
  localparam int SE_EN_BIT      = 0;
  localparam int FC_VSOR_BIT    = 3;
  // Extended index holding the third clock select bit, and its position
  localparam logic [7:0] EXT_CLK_IDX = 8'h00;
  localparam int EXT_CLK_BIT    = 0;
  localparam int TIMING_IDX_W   = 5;
  // Reset values
  localparam logic [7:0] OUTCTL_RST = 8'h00;
  localparam logic [7:0] SUBSYS_RST = 8'h01;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  // Trap set: legacy ports with no direct equivalent (emulated by software)
  localparam logic [15:0] TRAP_PORT_A = 16'h03b8;
  localparam logic [15:0] TRAP_PORT_B = 16'h03d8;
  localparam logic [15:0] TRAP_PORT_C = 16'h03d9;

  typedef enum logic [1:0] {
    VHIO_VS_RSVD = 2'b00,
    VHIO_VS_400  = 2'b01,
    VHIO_VS_350  = 2'b10,
    VHIO_VS_480  = 2'b11
  } vhio_vsize_e;

  typedef enum logic [2:0] {
    VHIO_CK_IN0   = 3'b000,
    VHIO_CK_IN1   = 3'b001,
    VHIO_CK_EXT   = 3'b010,
    VHIO_CK_NONE  = 3'b011,
    VHIO_CK_IN1D2 = 3'b100,
    VHIO_CK_IN2D2 = 3'b101,
    VHIO_CK_IN2   = 3'b110,
    VHIO_CK_IN3   = 3'b111
  } vhio_clk_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vhio_req_s;

  typedef struct packed {
    vhio_vsize_e vsize;
    logic        high_page;
    vhio_clk_e   clk_sel;
    logic        mem_decode_en;
    logic        color_map;
  } vhio_ctl_s;
endpackage

// ### testbench/vhio_decode_assertions.sv
// Port-level assertions for the host I/O decode
`timescale 1ns/1ps
module vhio_decode_chk (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire vhio_pkg::vhio_req_s host_req,
  input wire logic [7:0]          host_rdata,
  input wire logic                host_rvalid,
  input wire vhio_pkg::vhio_ctl_s ctl,
  input wire logic                retrace_irq_oe_n,
  input wire logic                nmi_oe_n,
  input wire logic                nmi_ack,
  input wire logic                xcvr_dir
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic        se_ff;
  logic        nxt_se;
  logic [15:0] a;
  logic        acc;
  assign a = host_req.addr;
  assign acc = se_ff && (host_req.rd || host_req.wr);
  assign nxt_se = (host_req.wr && a == vhio_pkg::PORT_SUBSYS_EN) ? host_req.wdata[0] : se_ff;
  always_ff @(posedge clock) begin
    se_ff <= !rst_n ? vhio_pkg::SUBSYS_RST[0] : nxt_se;
  end
  sequence s_oc_wr;
    acc && host_req.wr && a == vhio_pkg::PORT_OUTCTL_WR;
  endsequence
  sequence s_trap;
    acc && (a == vhio_pkg::TRAP_PORT_A || a == vhio_pkg::TRAP_PORT_B ||
      a == vhio_pkg::TRAP_PORT_C);
  endsequence
  a_read_answer: assert property (acc && host_req.rd |=> host_rvalid)
    else $error("accepted read got no answer");
  a_dir_read: assert property (host_rvalid |-> xcvr_dir)
    else $error("direction not toward system on read");
  a_dir_write: assert property (host_req.wr && !host_req.rd |=> !xcvr_dir)
    else $error("direction not toward device on write");
  a_ctl_follow: assert property (s_oc_wr |-> ##2 (
    ctl.color_map == $past(host_req.wdata[0], 2) && ctl.mem_decode_en == $past(host_req.wdata[1], 2)
    && ctl.high_page == $past(host_req.wdata[5], 2)
    && ctl.clk_sel[1:0] == $past(host_req.wdata[3:2], 2)
    && ctl.vsize == $past(host_req.wdata[7:6], 2))) else $error("control outputs stale");
  a_trap_nmi: assert property (s_trap |-> ##[1:3] !nmi_oe_n)
    else $error("trapped access raised no NMI");
  a_nmi_held: assert property (!nmi_oe_n && !nmi_ack && !$past(nmi_ack) |=> !nmi_oe_n)
    else $error("NMI released without acknowledge");
  a_off_range: assert property (acc && host_req.rd && !$past(host_req.wr)
    && (ctl.color_map ? a == vhio_pkg::PORT_STATUS1_MONO : a == vhio_pkg::PORT_STATUS1_COLOR)
    |=> host_rdata == vhio_pkg::BYTE_ZERO) else $error("inactive range port answered");
  a_irq_status: assert property (host_rvalid
    && $past(host_req.rd && a == vhio_pkg::PORT_STATUS0_RD) && $stable(retrace_irq_oe_n)
    && $past(retrace_irq_oe_n, 2) == retrace_irq_oe_n |-> host_rdata[7] == !retrace_irq_oe_n)
    else $error("pending bit disagrees with interrupt line");
endmodule
bind vhio_decode vhio_decode_chk u_chk (.clock(clock), .rst_n(rst_n), .host_req(host_req),
  .host_rdata(host_rdata), .host_rvalid(host_rvalid), .ctl(ctl), .nmi_ack(nmi_ack),
  .retrace_irq_oe_n(retrace_irq_oe_n), .nmi_oe_n(nmi_oe_n), .xcvr_dir(xcvr_dir));

// ### testbench/vhio_decode_tb.sv
// Self-checking bench for the host I/O register decode
`timescale 1ns/1ps
module vhio_decode_tb;
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  logic                vretrace = 1'b0;
  logic                retrace_clear = 1'b0;
  logic                monitor_switch = 1'b1;
  logic                nmi_ack = 1'b0;
  logic [7:0]          data_latch = 8'h5a;
  logic [1:0]          diag_color = 2'b10;
  vhio_pkg::vhio_req_s host_req;
  vhio_pkg::vhio_ctl_s ctl;
  logic [7:0]          host_rdata, d, v8;
  logic [15:0]         a16;
  logic [2:0]          k;
  logic                host_rvalid, retrace_irq_n, retrace_irq_oe_n, nmi_n, nmi_oe_n, v;
  logic                palette_write_n, unit_wr, vsync_or_display;
  logic [7:0]          palette_index_out;
  int                  num_errors = 0, check_count = 0, npw = 0, nuw = 0, n0;
  always #4 clock = ~clock;
  always @(posedge clock) begin
    if (palette_write_n === 1'b0) npw <= npw + 1;
    if (unit_wr === 1'b1) nuw <= nuw + 1;
  end
  vhio_decode u_dut (
    .clock(clock), .rst_n(rst_n), .host_req(host_req), .vretrace(vretrace), .hretrace(1'b0),
    .retrace_clear(retrace_clear), .monitor_switch(monitor_switch), .data_latch(data_latch),
    .attr_rd_data(8'h00), .unit_rd_data(8'h3c), .palette_rd_data(8'h00),
    .diag_color(diag_color), .nmi_ack(nmi_ack), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .ctl(ctl), .retrace_irq_n(retrace_irq_n),
    .retrace_irq_oe_n(retrace_irq_oe_n), .nmi_n(nmi_n), .nmi_oe_n(nmi_oe_n), .xcvr_dir(),
    .data_buffer_en_n(), .palette_write_n(palette_write_n), .palette_read_n(),
    .palette_index_out(palette_index_out), .unit_wr(unit_wr), .unit_addr(), .unit_wdata(),
    .vsync_or_display(vsync_or_display));
  vhio_host_model u_host (.clock(clock), .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] got;
    logic       ok;
    u_host.io_rd(a, got, ok);
    chk(8'(ok), 8'h01);
    chk(got, e);
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    rdc(vhio_pkg::PORT_OUTCTL_RD, vhio_pkg::OUTCTL_RST);
    rdc(vhio_pkg::PORT_SUBSYS_EN, vhio_pkg::SUBSYS_RST);
    chk(8'(ctl.mem_decode_en), 8'h00);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      v8 = {k[1:0], k[0], 1'b0, k[1:0], 2'b10};
      u_host.io_wr(vhio_pkg::PORT_EXT_IDX, vhio_pkg::EXT_CLK_IDX);
      u_host.io_wr(vhio_pkg::PORT_EXT_DAT, {7'h00, k[2]});
      u_host.io_wr(vhio_pkg::PORT_OUTCTL_WR, v8);
      rdc(vhio_pkg::PORT_OUTCTL_RD, v8);
      chk(8'(ctl.clk_sel), 8'(k));
      chk(8'(ctl.vsize), 8'(k[1:0]));
      chk(8'(ctl.high_page), 8'(k[0]));
      chk(8'(ctl.mem_decode_en), 8'h01);
    end
    $display("control codes done");
    for (int c = 0; c < 2; c++) begin
      u_host.io_wr(vhio_pkg::PORT_OUTCTL_WR, 8'h02 | 8'(c));
      n0 = nuw;
      u_host.io_wr(c ? vhio_pkg::PORT_TIMING_DAT_MONO : vhio_pkg::PORT_TIMING_DAT_COLOR, 8'h11);
      rdc(c ? vhio_pkg::PORT_STATUS1_MONO : vhio_pkg::PORT_STATUS1_COLOR, 8'h00);
      chk(8'(nuw - n0), 8'h00);
      u_host.io_wr(c ? vhio_pkg::PORT_TIMING_DAT_COLOR : vhio_pkg::PORT_TIMING_DAT_MONO, 8'h11);
      rdc(c ? vhio_pkg::PORT_STATUS1_COLOR : vhio_pkg::PORT_STATUS1_MONO, 8'h20);
      chk(8'(nuw - n0), 8'h01);
      rdc(c ? vhio_pkg::PORT_TIMING_DAT_COLOR : vhio_pkg::PORT_TIMING_DAT_MONO, 8'h3c);
    end
    $display("relocation done");
    vretrace = 1'b1;
    for (int n = 0; n < 10 && retrace_irq_oe_n !== 1'b0; n++) @(negedge clock);
    vretrace = 1'b0;
    if (retrace_irq_oe_n !== 1'b0) begin
      num_errors++;
      close_out();
    end
    rdc(vhio_pkg::PORT_STATUS0_RD, 8'h90);
    chk(8'(retrace_irq_n), 8'h00);
    repeat (4) @(negedge clock);
    chk(8'(retrace_irq_oe_n), 8'h00);
    retrace_clear = 1'b1;
    @(negedge clock);
    retrace_clear = 1'b0;
    rdc(vhio_pkg::PORT_STATUS0_RD, 8'h10);
    chk(8'(retrace_irq_oe_n), 8'h01);
    $display("retrace status done");
    for (int j = 0; j < 3; j++) begin
      a16 = (j == 0) ? vhio_pkg::TRAP_PORT_A : (j == 1) ? vhio_pkg::TRAP_PORT_B :
        vhio_pkg::TRAP_PORT_C;
      if (j == 1) begin
        u_host.io_wr(a16, 8'h00);
      end else begin
        u_host.io_rd(a16, d, v);
      end
      repeat (3) @(negedge clock);
      chk(8'(nmi_oe_n), 8'h00);
      chk(8'(nmi_n), 8'h00);
      nmi_ack = 1'b1;
      @(negedge clock);
      nmi_ack = 1'b0;
      repeat (3) @(negedge clock);
      chk(8'(nmi_oe_n), 8'h01);
    end
    $display("trap done");
    n0 = npw;
    u_host.io_wr(vhio_pkg::PORT_PAL_WR_IDX, 8'h42);
    repeat (2) @(negedge clock);
    chk(8'(npw != n0), 8'h01);
    chk(palette_index_out, 8'h42);
    u_host.io_wr(vhio_pkg::PORT_EXT_IDX, 8'h01);
    rdc(vhio_pkg::PORT_EXT_DAT, 8'h5a);
    rdc(16'h03bf, 8'h00);
    u_host.io_wr(16'h03cb, 8'hff);
    rdc(vhio_pkg::PORT_OUTCTL_RD, 8'h03);
    u_host.io_wr(vhio_pkg::PORT_SUBSYS_EN, 8'h00);
    u_host.io_rd(vhio_pkg::PORT_OUTCTL_RD, d, v);
    chk(8'(v), 8'h00);
    u_host.io_wr(vhio_pkg::PORT_OUTCTL_WR, 8'h00);
    u_host.io_wr(vhio_pkg::PORT_SUBSYS_EN, 8'h01);
    rdc(vhio_pkg::PORT_OUTCTL_RD, 8'h03);
    u_host.io_wr(vhio_pkg::PORT_STATUS1_MONO, 8'h08);
    rdc(vhio_pkg::PORT_FEATURE_RD, 8'h00);
    u_host.io_wr(vhio_pkg::PORT_STATUS1_COLOR, 8'h08);
    rdc(vhio_pkg::PORT_FEATURE_RD, 8'h08);
    chk(8'(vsync_or_display), 8'h01);
    $display("misc ports done");
    close_out();
  end
endmodule

// ### testbench/vhio_host_model.sv
// Processor I/O bus model: single-byte port reads and writes
`timescale 1ns/1ps
module vhio_host_model (
  input  wire logic           clock,
  output vhio_pkg::vhio_req_s host_req,
  input  wire logic [7:0]     host_rdata,
  input  wire logic           host_rvalid
);
  initial host_req = '0;
  // Released lines show the inverse of the last request, never a stale copy
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    if (a == vhio_pkg::PORT_PIXEL_MASK) return;
    @(negedge clock);
    host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clock);
    host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge clock);
    host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clock);
    host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    d = host_rdata;
    v = host_rvalid;
  endtask
endmodule
